// File: design/bme_core.sv
// Operation
// [RQ1] opcode 67h: bit AND, three bytes, six cycles; operand lsb picks form
// [RQ2] operand byte: register nibble high, bit index in bits 3..1, form lsb
// [RQ3] bit AND: indexed bit ANDed with bit 0, stored in destination bit
// [RQ4] opcode 17h: bit compare, three bytes, six cycles, form 0 only
// [RQ5] compare sets zero flag when bits equal, writes no operand
// [RQ6] compare clears sign, keeps carry, decimal-adjust, half-carry
// [RQ7] opcode 57h form 0: bit complement, two bytes, four cycles
// [RQ8] complement: zero flag from whole result, sign cleared, others kept
// [RQ9] opcode 77h form 0: bit clear, two bytes, four cycles
// [RQ10] bit clear changes no flag
// [RQ11] flags live in the flag register at full address D5h
// [RQ12] opcode 77h form 1: bit set, writes one into indexed bit
// [RQ13] third byte fetched only for bit AND and bit compare
//
// Register access over APB was decided locally.
`timescale 1ns/100ps
module bme_core
	import bme_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// status
	output logic busy_o
);

	// ************************************************
	// state
	// ************************************************
	typedef enum logic [1:0] {ST_IDLE, ST_OPND, ST_THIRD, ST_EXEC} bme_state_t;

	bme_state_t state;
	logic [3:0] cnt;
	logic [23:0] instr;
	bme_kind_t kind_q;
	logic [7:0] opnd_q;
	logic [7:0] third_q;
	logic [7:0] flags;
	logic [15:0][7:0] wregs;
	logic [15:0][7:0] fregs;
	logic illegal;
	logic done;
	logic need_third_q;

	// ************************************************
	// apb decode
	// ************************************************
	wire [9:0] idx = paddr_i[11:2];
	wire setup = psel_i & ~penable_i;
	wire access = psel_i & penable_i;
	wire hit_instr = (idx == IDX_INSTR);
	wire hit_ctrl = (idx == IDX_CTRL);
	wire hit_flags = (idx == IDX_FLAGS);
	wire hit_wreg = (idx[9:4] == IDX_WREG_PAGE);
	wire hit_freg = (idx[9:4] == IDX_FREG_PAGE);
	wire mapped = hit_instr | hit_ctrl | hit_flags | hit_wreg | hit_freg;
	wire busy = (state != ST_IDLE);
	// storage may not be written under a running instruction
	wire wr_refused = pwrite_i & busy & (hit_instr | hit_flags | hit_wreg | hit_freg);
	wire wr_ok = access & pwrite_i & mapped & ~wr_refused;
	assign pready_o = 1'b1;
	assign pslverr_o = access & (~mapped | wr_refused);
	assign busy_o = busy;

	// ************************************************
	// instruction decode of the loaded bytes
	// ************************************************
	wire [7:0] opc_in = instr[7:0];
	wire [7:0] opnd_in = instr[15:8];
	wire form_in = opnd_in[OPND_FORM]; // RQ2
	bme_kind_t kind_in;
	logic [1:0] bytes_in;
	logic [3:0] cyc_in;

	// opcode and form to kind, length and cycles
	always_comb begin
		kind_in = BK_NONE;
		bytes_in = BYTES_SHORT;
		cyc_in = CYC_SHORT;
		case (opc_in)
			OPC_BAND: begin
				kind_in = BK_AND; // RQ1
				bytes_in = BYTES_LONG;
				cyc_in = CYC_LONG;
			end
			OPC_BIT_CMP: begin
				kind_in = form_in ? BK_NONE : BK_CMP; // RQ4
				bytes_in = BYTES_LONG;
				cyc_in = CYC_LONG;
			end
			OPC_BIT_CPL: begin
				kind_in = form_in ? BK_NONE : BK_CPL; // RQ7
			end
			OPC_BITRS: begin
				kind_in = form_in ? BK_SET : BK_CLR; // RQ9 RQ12
			end
			default: begin
				kind_in = BK_NONE;
			end
		endcase
	end

	wire start_req = wr_ok & hit_ctrl & pwdata_i[CTRL_RUN];
	// a start under a running instruction is ignored, not queued
	wire start = start_req & ~busy & (kind_in != BK_NONE);
	wire reject = start_req & (kind_in == BK_NONE);
	// a long instruction has its third byte still to fetch
	wire need_third = (kind_in == BK_AND) | (kind_in == BK_CMP); // RQ13
	wire commit = (state == ST_EXEC) & (cnt == 4'd0);

	// ************************************************
	// operand selection and execution
	// ************************************************
	wire [3:0] wsel = opnd_q[OPND_REG_MSB:OPND_REG_LSB]; // RQ2
	wire [2:0] bidx = opnd_q[OPND_IDX_MSB:OPND_IDX_LSB]; // RQ2
	wire form_q = opnd_q[OPND_FORM];
	wire full_is_flags = (third_q == FLAGS_ADDR); // RQ11
	wire [7:0] work_val = wregs[wsel];
	wire [7:0] full_val = full_is_flags ? flags : fregs[third_q[3:0]];
	wire [7:0] work_new;
	wire [7:0] full_new;
	wire [7:0] flags_new;
	wire work_we;
	wire full_we;

	bme_bit_unit u_bit (
		.kind_i(kind_q),
		.form_i(form_q),
		.idx_i(bidx),
		.work_val_i(work_val),
		.full_val_i(full_val),
		.flags_i(flags),
		.work_new_o(work_new),
		.work_we_o(work_we),
		.full_new_o(full_new),
		.full_we_o(full_we),
		.flags_o(flags_new)
	);

	// a bit AND into the flag register itself: flag effect wins on z and s
	logic [7:0] flags_exec;
	always_comb begin
		flags_exec = flags_new;
		if (full_we && full_is_flags) begin
			flags_exec = full_new;
			flags_exec[FLG_Z] = flags_new[FLG_Z];
			flags_exec[FLG_S] = flags_new[FLG_S];
		end
	end

	// ************************************************
	// sequencer
	// ************************************************
	// cycle count loaded at start counts every busy cycle down to commit
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state <= ST_IDLE;
			cnt <= 4'd0;
			kind_q <= BK_NONE;
			opnd_q <= 8'h00;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start) begin
						state <= ST_OPND;
						cnt <= cyc_in - 4'd1; // RQ1 RQ4 RQ7 RQ9
						kind_q <= kind_in;
					end
				end
				ST_OPND: begin
					opnd_q <= opnd_in;
					cnt <= cnt - 4'd1;
					state <= need_third_q ? ST_THIRD : ST_EXEC; // RQ13
				end
				ST_THIRD: begin
					cnt <= cnt - 4'd1;
					state <= ST_EXEC;
				end
				ST_EXEC: begin
					if (cnt == 4'd0) begin
						state <= ST_IDLE;
					end else begin
						cnt <= cnt - 4'd1;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// length class kept from start, since the opcode byte is consumed there
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			need_third_q <= 1'b0;
		end else if (start) begin
			need_third_q <= need_third;
		end
	end

	// third byte is read only in its own fetch cycle
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			third_q <= 8'h00;
		end else if (state == ST_THIRD) begin
			third_q <= instr[23:16]; // RQ13
		end
	end

	// ************************************************
	// storage: instruction bytes, registers, flags
	// ************************************************
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			instr <= 24'h000000;
		end else if (wr_ok && hit_instr) begin
			instr <= pwdata_i[23:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wregs <= '0;
		end else if (commit && work_we) begin
			wregs[wsel] <= work_new; // RQ3 RQ7 RQ9 RQ12
		end else if (wr_ok && hit_wreg) begin
			wregs[idx[3:0]] <= pwdata_i[7:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			fregs <= '0;
		end else if (commit && full_we && !full_is_flags) begin
			fregs[third_q[3:0]] <= full_new; // RQ3
		end else if (wr_ok && hit_freg) begin
			fregs[idx[3:0]] <= pwdata_i[7:0];
		end
	end

	// flag register; bit clear and bit set pass flags through unchanged
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			flags <= FLAGS_RST;
		end else if (commit) begin
			flags <= flags_exec; // RQ5 RQ6 RQ8 RQ10 RQ11
		end else if (wr_ok && hit_flags) begin
			flags <= pwdata_i[7:0];
		end
	end

	// sticky status, an event in the clearing cycle wins
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			illegal <= 1'b0;
			done <= 1'b0;
		end else begin
			illegal <= reject | (illegal & ~(wr_ok & hit_ctrl & pwdata_i[CTRL_ILLEGAL]));
			done <= commit | (done & ~(wr_ok & hit_ctrl & pwdata_i[CTRL_DONE]));
		end
	end

	// ************************************************
	// read data, sampled in the setup cycle
	// ************************************************
	wire [7:0] ctrl_rd = {5'b00000, done, illegal, busy};
	wire [31:0] rd_mux = hit_instr ? {8'h00, instr} :
		hit_ctrl ? {24'h000000, ctrl_rd} :
		hit_flags ? {24'h000000, flags} :
		hit_wreg ? {24'h000000, wregs[idx[3:0]]} :
		hit_freg ? {24'h000000, fregs[idx[3:0]]} : 32'h00000000;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			prdata_o <= 32'h00000000;
		end else if (setup) begin
			prdata_o <= rd_mux; // RQ11
		end
	end

	// ************************************************
	// checks
	// ************************************************
	wire [7:0] onehot = 8'h01 << bidx;

	sequence s_run6;
		busy [*6] ##1 !busy;
	endsequence

	sequence s_run4;
		busy [*4] ##1 !busy;
	endsequence

	property p_band_six;
		@(posedge clk_i) disable iff (!rst_n_i) start && opc_in == OPC_BAND |=> s_run6;
	endproperty
	a_band_six: assert property (p_band_six) else $error("bit AND not six cycles"); // RQ1

	property p_cmp_six;
		@(posedge clk_i) disable iff (!rst_n_i) start && opc_in == OPC_BIT_CMP |=> s_run6;
	endproperty
	a_cmp_six: assert property (p_cmp_six) else $error("compare not six cycles"); // RQ4

	property p_short_four;
		@(posedge clk_i) disable iff (!rst_n_i)
			start && (opc_in == OPC_BIT_CPL || opc_in == OPC_BITRS) |=> s_run4;
	endproperty
	a_short_four: assert property (p_short_four) else $error("short op not four cycles"); // RQ7

	property p_no_third;
		@(posedge clk_i) disable iff (!rst_n_i)
			start && !need_third |=> (state != ST_THIRD) [*4];
	endproperty
	a_no_third: assert property (p_no_third) else $error("third byte fetched"); // RQ13

	property p_third_stable;
		@(posedge clk_i) disable iff (!rst_n_i) state != ST_THIRD |=> $stable(third_q);
	endproperty
	a_third_stable: assert property (p_third_stable) else $error("third byte moved"); // RQ13

	property p_and_bit0;
		@(posedge clk_i) disable iff (!rst_n_i)
			commit && kind_q == BK_AND && !form_q
			|=> wregs[$past(wsel)][0] == ($past(work_val[0]) & $past(full_val[bidx]));
	endproperty
	a_and_bit0: assert property (p_and_bit0) else $error("bit AND result wrong"); // RQ3

	property p_cmp;
		@(posedge clk_i) disable iff (!rst_n_i) commit && kind_q == BK_CMP
			|=> $stable(wregs) && $stable(fregs) && !flags[FLG_S]
			&& flags[FLG_Z] == ($past(work_val[0]) == $past(full_val[bidx]))
			&& flags[FLG_C] == $past(flags[FLG_C]) && flags[FLG_D] == $past(flags[FLG_D])
			&& flags[FLG_H] == $past(flags[FLG_H]);
	endproperty
	a_cmp: assert property (p_cmp) else $error("compare effect wrong"); // RQ5 RQ6

	property p_cpl;
		@(posedge clk_i) disable iff (!rst_n_i) commit && kind_q == BK_CPL
			|=> (wregs[$past(wsel)] ^ $past(work_val)) == $past(onehot)
			&& flags[FLG_Z] == (wregs[$past(wsel)] == 8'h00) && !flags[FLG_S];
	endproperty
	a_cpl: assert property (p_cpl) else $error("complement wrong"); // RQ8

	property p_clr_set;
		@(posedge clk_i) disable iff (!rst_n_i) commit && (kind_q == BK_CLR || kind_q == BK_SET)
			|=> $stable(flags)
			&& wregs[$past(wsel)] == ($past(kind_q == BK_SET) ? ($past(work_val) | $past(onehot))
			: ($past(work_val) & ~$past(onehot)));
	endproperty
	a_clr_set: assert property (p_clr_set) else $error("clear or set wrong"); // RQ9 RQ10 RQ12

	property p_flags_read;
		@(posedge clk_i) disable iff (!rst_n_i)
			setup && hit_flags |=> prdata_o == {24'h000000, $past(flags)};
	endproperty
	a_flags_read: assert property (p_flags_read) else $error("flag read wrong"); // RQ11

endmodule : bme_core

// File: design/bme_pkg.sv
package bme_pkg;

	// ************************************************
	// apb map, register indexes (byte address = index * 4)
	// ************************************************
	localparam int unsigned ADDR_W = 12;
	localparam logic [9:0] IDX_INSTR = 10'h000;
	localparam logic [9:0] IDX_CTRL = 10'h001;
	localparam logic [5:0] IDX_WREG_PAGE = 6'h01;
	localparam logic [5:0] IDX_FREG_PAGE = 6'h02;
	localparam logic [9:0] IDX_FLAGS = 10'h0D5;

	// full register address of the flag register
	localparam logic [7:0] FLAGS_ADDR = 8'hD5;
	localparam logic [7:0] FLAGS_RST = 8'h00;

	// ************************************************
	// instruction encoding
	// ************************************************
	localparam logic [7:0] OPC_BAND = 8'h67;
	localparam logic [7:0] OPC_BIT_CMP = 8'h17;
	localparam logic [7:0] OPC_BIT_CPL = 8'h57;
	localparam logic [7:0] OPC_BITRS = 8'h77;
	localparam int unsigned OPND_REG_MSB = 7;
	localparam int unsigned OPND_REG_LSB = 4;
	localparam int unsigned OPND_IDX_MSB = 3;
	localparam int unsigned OPND_IDX_LSB = 1;
	localparam int unsigned OPND_FORM = 0;
	localparam logic [1:0] BYTES_LONG = 2'd3;
	localparam logic [1:0] BYTES_SHORT = 2'd2;
	localparam logic [3:0] CYC_LONG = 4'd6;
	localparam logic [3:0] CYC_SHORT = 4'd4;

	// ************************************************
	// flag register layout
	// ************************************************
	localparam int unsigned FLG_C = 7;
	localparam int unsigned FLG_Z = 6;
	localparam int unsigned FLG_S = 5;
	localparam int unsigned FLG_V = 4;
	localparam int unsigned FLG_D = 3;
	localparam int unsigned FLG_H = 2;

	// ************************************************
	// control/status register bits
	// ************************************************
	localparam int unsigned CTRL_RUN = 0;
	localparam int unsigned CTRL_ILLEGAL = 1;
	localparam int unsigned CTRL_DONE = 2;

	typedef enum logic [2:0] {
		BK_NONE,
		BK_AND,
		BK_CMP,
		BK_CPL,
		BK_CLR,
		BK_SET
	} bme_kind_t;

endpackage : bme_pkg

// File: design/bme_bit_unit.sv
`timescale 1ns/100ps
module bme_bit_unit
	import bme_pkg::*;
(
	// operation select
	input wire bme_kind_t kind_i,
	input wire logic form_i,
	input wire logic [2:0] idx_i,
	// operand values
	input wire logic [7:0] work_val_i,
	input wire logic [7:0] full_val_i,
	input wire logic [7:0] flags_i,
	// results
	output logic [7:0] work_new_o,
	output logic work_we_o,
	output logic [7:0] full_new_o,
	output logic full_we_o,
	output logic [7:0] flags_o
);
	logic res;

	// one-bit operation and flag effect; v is left as it was (undefined)
	always_comb begin
		res = 1'b0;
		work_new_o = work_val_i;
		work_we_o = 1'b0;
		full_new_o = full_val_i;
		full_we_o = 1'b0;
		flags_o = flags_i;
		case (kind_i)
			BK_AND: begin
				if (!form_i) begin
					res = work_val_i[0] & full_val_i[idx_i]; // RQ3
					work_new_o[0] = res; // RQ1
					work_we_o = 1'b1;
				end else begin
					res = full_val_i[idx_i] & work_val_i[0]; // RQ3
					full_new_o[idx_i] = res; // RQ1
					full_we_o = 1'b1;
				end
				flags_o[FLG_Z] = ~res;
				flags_o[FLG_S] = 1'b0;
			end
			BK_CMP: begin
				flags_o[FLG_Z] = (work_val_i[0] == full_val_i[idx_i]); // RQ5
				flags_o[FLG_S] = 1'b0; // RQ6
			end
			BK_CPL: begin
				work_new_o[idx_i] = ~work_val_i[idx_i]; // RQ7
				work_we_o = 1'b1;
				flags_o[FLG_Z] = (work_new_o == 8'h00); // RQ8
				flags_o[FLG_S] = 1'b0; // RQ8
			end
			BK_CLR: begin
				work_new_o[idx_i] = 1'b0; // RQ9
				work_we_o = 1'b1;
			end
			BK_SET: begin
				work_new_o[idx_i] = 1'b1; // RQ12
				work_we_o = 1'b1;
			end
			default: begin
				res = 1'b0;
			end
		endcase
	end

endmodule : bme_bit_unit

// File: tb/tb_bit_manipulation_execute.sv
`timescale 1ns/100ps
module tb_bit_manipulation_execute import bme_pkg::*; ();

	// ************************************************
	// signals and case table
	// ************************************************
	typedef struct packed {
		logic [7:0] opc;
		logic [7:0] opnd;
		logic [3:0] wi;
		logic [7:0] w0;
		logic [7:0] f0;
		logic [7:0] fl0;
		logic [7:0] w1;
		logic [7:0] f1;
		logic [7:0] fl1;
		logic [3:0] cyc;
	} bme_row_t;

	localparam logic [ADDR_W-1:0] A_INSTR = {IDX_INSTR, 2'b00};
	localparam logic [ADDR_W-1:0] A_CTRL = {IDX_CTRL, 2'b00};
	localparam logic [ADDR_W-1:0] A_FREG = {IDX_FREG_PAGE, 4'h1, 2'b00};
	localparam logic [ADDR_W-1:0] A_FLAGS = {IDX_FLAGS, 2'b00};

	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, busy;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd_data;
	logic rd_err;
	logic [3:0] n_busy;
	int failures = 0;
	int checks_done = 0;
	// third byte is always 01h, so the full register is the one at A_FREG
	bme_row_t rows [8] = '{
		'{OPC_BAND, 8'h12, 4'h1, 8'h07, 8'h05, 8'hBC, 8'h06, 8'h05, 8'hDC, CYC_LONG},
		'{OPC_BAND, 8'h13, 4'h1, 8'h06, 8'h07, 8'hBC, 8'h06, 8'h05, 8'hDC, CYC_LONG},
		'{OPC_BIT_CMP, 8'h12, 4'h1, 8'h07, 8'h01, 8'hFC, 8'h07, 8'h01, 8'h9C, CYC_LONG},
		'{OPC_BIT_CMP, 8'h10, 4'h1, 8'h07, 8'h01, 8'h20, 8'h07, 8'h01, 8'h40, CYC_LONG},
		'{OPC_BIT_CPL, 8'h12, 4'h1, 8'h07, 8'h00, 8'hFC, 8'h05, 8'h00, 8'h9C, CYC_SHORT},
		'{OPC_BIT_CPL, 8'h16, 4'h1, 8'h08, 8'h00, 8'hA0, 8'h00, 8'h00, 8'hC0, CYC_SHORT},
		'{OPC_BITRS, 8'h52, 4'h5, 8'h07, 8'h00, 8'h5C, 8'h05, 8'h00, 8'h5C, CYC_SHORT},
		'{OPC_BITRS, 8'h17, 4'h1, 8'h07, 8'h00, 8'hE4, 8'h0F, 8'h00, 8'hE4, CYC_SHORT}
	};
	// illegal opcode and form pairs, operand byte above opcode
	logic [15:0] bad [3] = '{16'h1317, 16'h1357, 16'h1012};

	bme_core dut_u (
		.clk_i(clk),
		.rst_n_i(rst_n),
		.psel_i(psel),
		.penable_i(penable),
		.pwrite_i(pwrite),
		.paddr_i(paddr),
		.pwdata_i(pwdata),
		.prdata_o(prdata),
		.pready_o(pready),
		.pslverr_o(pslverr),
		.busy_o(busy)
	);

	// 100 MHz core clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ************************************************
	// bus and check tasks
	// ************************************************
	function automatic logic [ADDR_W-1:0] wreg_addr(input logic [3:0] wi);
		return {IDX_WREG_PAGE, wi, 2'b00};
	endfunction : wreg_addr

	// apb transfer; waits on pready even though the slave has no wait states
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		// a slave that never answers counts as a mismatch
		if (pready !== 1'b1) begin
			failures++;
		end
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a);
		apb(1'b0, a, 32'h0000_0000);
	endtask : rd

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic start(input logic [23:0] instr);
		wr(A_INSTR, {8'h00, instr});
		wr(A_CTRL, 32'h0000_0001);
	endtask : start

	// counts busy cycles at falling edges, bounded so a stuck busy cannot hang
	task automatic wait_idle();
		n_busy = 4'h0;
		@(negedge clk);
		while (busy === 1'b1 && n_busy < 4'hF) begin
			n_busy++;
			@(negedge clk);
		end
	endtask : wait_idle

	task automatic end_sim();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim

	// ************************************************
	// stimulus
	// ************************************************
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = 32'h0000_0000;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk("busy after reset", {31'h0, busy}, 32'h0000_0000);
		chk("pready after reset", {31'h0, pready}, 32'h0000_0001);
		rd(A_FLAGS);
		chk("flags reset", rd_data, {24'h0, FLAGS_RST});
		rd(A_CTRL);
		chk("ctrl reset", rd_data, 32'h0000_0000);
		// table cases: preload operands and flags, run, read everything back
		foreach (rows[i]) begin
			wr(wreg_addr(rows[i].wi), {24'h0, rows[i].w0});
			wr(A_FREG, {24'h0, rows[i].f0});
			wr(A_FLAGS, {24'h0, rows[i].fl0});
			start({8'h01, rows[i].opnd, rows[i].opc});
			wait_idle();
			chk("busy cycles", {28'h0, n_busy}, {28'h0, rows[i].cyc});
			rd(wreg_addr(rows[i].wi));
			chk("working reg", rd_data, {24'h0, rows[i].w1});
			rd(A_FREG);
			chk("full reg", rd_data, {24'h0, rows[i].f1});
			rd(A_FLAGS);
			chk("flags", rd_data, {24'h0, rows[i].fl1});
			rd(A_CTRL);
			chk("done status", rd_data, 32'h0000_0004);
			wr(A_CTRL, 32'h0000_0004);
		end
		// unmapped place answers with an error and zero data
		rd(12'h300);
		chk("unmapped err", {31'h0, rd_err}, 32'h0000_0001);
		chk("unmapped data", rd_data, 32'h0000_0000);
		// write during a run is refused; bit 7 of r2 flips, flags from E4h
		wr(wreg_addr(4'h2), 32'h0000_00F0);
		start({8'h00, 8'h2E, OPC_BIT_CPL});
		wr(wreg_addr(4'h2), 32'h0000_00FF);
		chk("busy write err", {31'h0, rd_err}, 32'h0000_0001);
		wait_idle();
		rd(wreg_addr(4'h2));
		chk("r2 after complement", rd_data, 32'h0000_0070);
		rd(A_FLAGS);
		chk("flags after complement", rd_data, 32'h0000_0084);
		// refused opcodes and forms must not run and must raise the illegal status
		foreach (bad[k]) begin
			wr(A_CTRL, 32'h0000_0006);
			start({8'h01, bad[k]});
			@(negedge clk);
			chk("illegal busy", {31'h0, busy}, 32'h0000_0000);
			rd(A_CTRL);
			chk("illegal status", rd_data, 32'h0000_0002);
		end
		end_sim();
	end

	// watchdog well beyond the expected run of a few hundred cycles
	initial begin
		#300000;
		failures++;
		end_sim();
	end

endmodule : tb_bit_manipulation_execute
